// ==== verilog/obcd_pkg.sv ====
// Purpose: Shared constants and types for the option byte configuration decoder.
// Assumes: Two 8-bit static option bytes, APB register access, 20 MHz CLK.
// Notes:   Every offset, field position, option byte reset value and cycle count lives here.

package obcd_pkg;

   // ************************************************************
   // Bus map
   // ************************************************************
   localparam logic [7:0] ADDR_CTRL   = 8'h00;
   localparam logic [7:0] ADDR_BYTE0  = 8'h04;
   localparam logic [7:0] ADDR_BYTE1  = 8'h08;
   localparam logic [7:0] ADDR_STATUS = 8'h0c;
   localparam int         CTRL_ERASE  = 0;

   localparam int STAT_LOADED  = 0;
   localparam int STAT_PROG    = 1;
   localparam int STAT_BUSY    = 2;
   localparam int STAT_PROTECT = 3;
   localparam int STAT_BYTE0   = 8;
   localparam int STAT_BYTE1   = 16;

   // ************************************************************
   // Option byte layout
   // ************************************************************
   localparam int B0_HALT_RST = 7;
   localparam int B0_DOG_SW   = 6;
   localparam int B0_VD_HI    = 4;
   localparam int B0_VD_LO    = 3;
   localparam int B0_PKG_LOW  = 1;
   localparam int B0_PROTECT  = 0;
   localparam int B1_PKG_HIGH = 7;
   localparam int B1_RESET_PHASE_LENGTH_SEL     = 6;
   localparam int B1_OSC_HI   = 5;
   localparam int B1_OSC_LO   = 4;
   localparam int B1_RANGE_HI = 3;
   localparam int B1_RANGE_LO = 1;
   localparam int B1_DBL_OFF  = 0;

   // Erased cells read all ones; delivered parts carry the shipping pattern.
   localparam logic [7:0] ERASED_BYTE = 8'hff;
   localparam logic [7:0] SHIP_BYTE0  = 8'he7;
   localparam logic [7:0] SHIP_BYTE1  = 8'hef;

   localparam logic [1:0] VD_OFF      = 2'h3;
   localparam logic [1:0] OSC_RES     = 2'h0;
   localparam logic [1:0] OSC_RC      = 2'h2;
   localparam logic [2:0] RANGE_2_4   = 3'h1;

   localparam logic [12:0] RESET_CYCLES_LONG  = 13'h1000;
   localparam logic [12:0] RESET_CYCLES_SHORT = 13'h0100;

   // ************************************************************
   // Types
   // ************************************************************
   typedef enum logic [1:0] {
      ST_LOAD      = 2'b00,
      ST_IDLE      = 2'b01,
      ST_WIPE_USER = 2'b11,
      ST_WIPE_OPT  = 2'b10
   } obcd_state_type;

   typedef struct packed {
      logic        halt_reset_when_dog_active;
      logic        dog_software_select;
      logic        dog_always_on;
      logic [1:0]  voltage_detect_threshold;
      logic        low_supply_reset_detector;
      logic        auxiliary_supply_detector;
      logic        readout_protect;
      logic        package_sel_high;
      logic [12:0] reset_phase_cycles;
      logic [1:0]  clock_source_type;
      logic [2:0]  clock_freq_range;
      logic        doubler_enable;
   } obcd_options_type;

   typedef struct packed {
      logic [7:0] byte0;
      logic [7:0] byte1;
   } obcd_bytes_type;

endpackage : obcd_pkg

// ==== verilog/obcd_cells.sv ====
// Purpose: Non-volatile storage of the two option bytes.
// Assumes: NPOR only models first power-up of a fresh part.
// Notes:   A mask-coded build has no writable cells at all.

`timescale 1ns/1ps

module obcd_cells #(
   parameter bit         MASK_CODED = 1'b0,
   parameter logic [7:0] MASK_BYTE0 = obcd_pkg::SHIP_BYTE0,
   parameter logic [7:0] MASK_BYTE1 = obcd_pkg::SHIP_BYTE1
) (
   input  wire logic                     clk,      // Main clock.
   input  wire logic                     npor,     // Power-on state of a fresh part.
   input  wire logic                     wr_en,    // Write one cell.
   input  wire logic                     wr_sel,   // Cell index.
   input  wire logic [7:0]               wr_data,  // Write value.
   input  wire logic                     erase,    // Erase both cells.
   output obcd_pkg::obcd_bytes_type      cells     // Stored bytes.
);

   obcd_pkg::obcd_bytes_type store;
   obcd_pkg::obcd_bytes_type next_store;

   always_comb begin
      next_store = store;
      if (erase) begin
         next_store.byte0 = obcd_pkg::ERASED_BYTE;
         next_store.byte1 = obcd_pkg::ERASED_BYTE;
      end else if (wr_en && !wr_sel) begin
         next_store.byte0 = wr_data;
      end else if (wr_en) begin
         next_store.byte1 = wr_data;
      end
   end

   always_ff @(posedge clk or negedge npor) begin
      if (!npor) begin
         store <= {obcd_pkg::SHIP_BYTE0, obcd_pkg::SHIP_BYTE1};
      end else begin
         store <= next_store;
      end
   end

   assign cells = MASK_CODED ? {MASK_BYTE0, MASK_BYTE1} : store;

endmodule : obcd_cells

// ==== verilog/obcd_decode.sv ====
// Purpose: Turns two raw option bytes into named hardware options.
// Assumes: Purely combinational; the caller registers the result.
// Notes:   The package selection low bit is deliberately ignored.

`timescale 1ns/1ps

module obcd_decode #(
   parameter bit MASK_CODED = 1'b0
) (
   input  obcd_pkg::obcd_bytes_type   raw,   // Latched option bytes.
   output obcd_pkg::obcd_options_type opt    // Decoded options.
);

   always_comb begin
      opt = '0;
      opt.halt_reset_when_dog_active = raw.byte0[obcd_pkg::B0_HALT_RST];
      opt.dog_software_select = raw.byte0[obcd_pkg::B0_DOG_SW];
      opt.dog_always_on       = !raw.byte0[obcd_pkg::B0_DOG_SW];
      opt.voltage_detect_threshold  = raw.byte0[obcd_pkg::B0_VD_HI:obcd_pkg::B0_VD_LO];
      opt.low_supply_reset_detector = opt.voltage_detect_threshold != obcd_pkg::VD_OFF;
      opt.auxiliary_supply_detector = opt.voltage_detect_threshold != obcd_pkg::VD_OFF;
      opt.readout_protect = MASK_CODED ? raw.byte0[obcd_pkg::B0_PROTECT] : !raw.byte0[obcd_pkg::B0_PROTECT];
      opt.package_sel_high = raw.byte1[obcd_pkg::B1_PKG_HIGH];
      opt.reset_phase_cycles = raw.byte1[obcd_pkg::B1_RESET_PHASE_LENGTH_SEL] ? obcd_pkg::RESET_CYCLES_SHORT
                                                              : obcd_pkg::RESET_CYCLES_LONG;
      opt.clock_source_type = raw.byte1[obcd_pkg::B1_OSC_HI:obcd_pkg::B1_OSC_LO];
      opt.clock_freq_range = raw.byte1[obcd_pkg::B1_RANGE_HI:obcd_pkg::B1_RANGE_LO];
      opt.doubler_enable = !raw.byte1[obcd_pkg::B1_DBL_OFF];
   end

endmodule : obcd_decode

// ==== verilog/obcd_option_loader.sv ====
// Purpose: Option byte store, reset-time loader and decoder with APB access.
// Assumes: PROG_MODE and USER_ERASE_DONE are asynchronous pins.
// Notes:   Decoded outputs change only on the load that follows each reset.
//
// Summary of operation
// - Option bytes unmapped, accessible in programming only
// - Erased option byte reads all ones
// - Delivered parts select internal RC clock
// - Mask variant values fixed in hardware
// - Byte0 bit7 chooses reset on halt
// - Byte0 bit6 picks hardware or software watchdog
// - Byte0 bits4:3 set detector thresholds
// - Package low bit has no effect
// - Protect bit zero blocks read and write
// - Protected erase wipes user memory first
// - Byte1 bit7 selects package bonding
// - Unbonded pads forced pulled-up inputs after reset
// - Byte1 bit6 picks 4096 or 256 cycles
// - Byte1 bits5:4 choose main clock source
// - Byte1 bits3:1 choose frequency range
// - Byte1 bit0 low enables clock doubler
// - Protect polarity inverted between mask and flash

`timescale 1ns/1ps

module obcd_option_loader #(
   parameter bit         MASK_CODED  = 1'b0,
   parameter logic [7:0] MASK_BYTE0  = obcd_pkg::SHIP_BYTE0,
   parameter logic [7:0] MASK_BYTE1  = obcd_pkg::SHIP_BYTE1,
   parameter logic [7:0] UNBONDED_P1 = 8'h00,
   parameter logic [7:0] UNBONDED_P0 = 8'h00
) (
   input  wire logic                 CLK,               // Main CPU clock.
   input  wire logic                 NRST,              // System reset, active low.
   input  wire logic                 NPOR,              // Power-on of a fresh part, active low.
   input  wire logic                 PSEL,              // APB select.
   input  wire logic                 PENABLE,           // APB access phase.
   input  wire logic                 PWRITE,            // APB direction.
   input  wire logic [7:0]           PADDR,             // APB byte address.
   input  wire logic [31:0]          PWDATA,            // APB write data.
   output logic                      PREADY,            // APB ready.
   output logic [31:0]               PRDATA,            // APB read data.
   output logic                      PSLVERR,           // APB error.
   input  wire logic                 PROG_MODE,         // Programming mode pin.
   output logic                      USER_ERASE_REQ,    // Request to wipe user memory.
   input  wire logic                 USER_ERASE_DONE,   // User memory wipe finished.
   output obcd_pkg::obcd_options_type OPTIONS,          // Decoded options.
   output logic                      READ_BLOCK,        // Program memory read-out blocked.
   output logic                      WRITE_BLOCK,       // Program memory writes blocked.
   output logic [7:0]                PAD_PULLUP_FORCE,  // Pads held as pulled-up inputs.
   output logic                      LOADED             // Options valid.
);

   // ************************************************************
   // Pin synchronisers
   // ************************************************************
   logic [1:0] prog_sync;
   logic [1:0] done_sync;
   logic [1:0] next_prog_sync;
   logic [1:0] next_done_sync;

   logic       prog;
   logic       done;

   // Logic reads only the second stage.
   always_comb begin
      next_prog_sync = {prog_sync[0], PROG_MODE};
      next_done_sync = {done_sync[0], USER_ERASE_DONE};
   end

   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         prog_sync <= 2'h0;
         done_sync <= 2'h0;
      end else begin
         prog_sync <= next_prog_sync;
         done_sync <= next_done_sync;
      end
   end

   assign prog = prog_sync[1];
   assign done = done_sync[1];

   // ************************************************************
   // Storage and decode
   // ************************************************************
   obcd_pkg::obcd_bytes_type   cells;
   obcd_pkg::obcd_bytes_type   latch;
   obcd_pkg::obcd_bytes_type   next_latch;
   obcd_pkg::obcd_options_type decoded;
   obcd_pkg::obcd_options_type next_options;
   obcd_pkg::obcd_state_type   state;
   obcd_pkg::obcd_state_type   next_state;

   // Cell controls and next values.
   logic                       cell_wr;
   logic                       cell_sel;
   logic                       cell_erase;
   logic                       next_loaded;
   logic                       next_erase_req;
   logic [7:0]                 next_pads;

   obcd_cells #(
      .MASK_CODED (MASK_CODED),
      .MASK_BYTE0 (MASK_BYTE0),
      .MASK_BYTE1 (MASK_BYTE1)
   ) u_cells (
      .clk     (CLK),
      .npor    (NPOR),
      .wr_en   (cell_wr),
      .wr_sel  (cell_sel),
      .wr_data (PWDATA[7:0]),
      .erase   (cell_erase),
      .cells   (cells)
   );

   obcd_decode #(
      .MASK_CODED (MASK_CODED)
   ) u_decode (
      .raw (latch),
      .opt (decoded)
   );

   // ************************************************************
   // APB decode
   // ************************************************************
   logic access;
   logic hit_ctrl;
   logic hit_b0;
   logic hit_b1;
   logic hit_stat;
   logic cell_ok;
   logic bad;

   // Exact match only, so cells never alias.
   function automatic logic addr_is(input logic [7:0] addr, input logic [7:0] offset);
      return addr == offset;
   endfunction : addr_is

   assign access   = PSEL && PENABLE;
   assign hit_ctrl = addr_is(PADDR, obcd_pkg::ADDR_CTRL);
   assign hit_b0   = addr_is(PADDR, obcd_pkg::ADDR_BYTE0);
   assign hit_b1   = addr_is(PADDR, obcd_pkg::ADDR_BYTE1);
   assign hit_stat = addr_is(PADDR, obcd_pkg::ADDR_STATUS);
   assign cell_ok  = prog && (state == obcd_pkg::ST_IDLE);

   always_comb begin
      bad = 1'b0;
      if (hit_b0 || hit_b1) begin
         bad = !cell_ok || (PWRITE && MASK_CODED);
      end else if (hit_ctrl) begin
         // Harmless unless erase is asked.
         bad = PWRITE && PWDATA[obcd_pkg::CTRL_ERASE] && (!cell_ok || MASK_CODED);
      end else if (hit_stat) begin
         // Status is read-only.
         bad = PWRITE;
      end else begin
         bad = 1'b1;
      end
   end

   // No wait states are ever inserted.
   assign PREADY  = 1'b1;
   assign PSLVERR = access && bad;

   logic [31:0] next_rdata;
   logic [31:0] rdata;

   always_comb begin
      next_rdata = 32'h0000_0000;
      if (PSEL && !PENABLE && !PWRITE) begin
         if (hit_b0 && cell_ok) begin
            next_rdata = {24'h00_0000, cells.byte0};
         end else if (hit_b1 && cell_ok) begin
            next_rdata = {24'h00_0000, cells.byte1};
         end else if (hit_stat) begin
            // Reports the latch, not the cells.
            next_rdata[obcd_pkg::STAT_LOADED]  = LOADED;
            next_rdata[obcd_pkg::STAT_PROG]    = prog;
            next_rdata[obcd_pkg::STAT_BUSY]    = state[1];
            next_rdata[obcd_pkg::STAT_PROTECT] = OPTIONS.readout_protect;
            next_rdata[obcd_pkg::STAT_BYTE0 +: 8] = latch.byte0;
            next_rdata[obcd_pkg::STAT_BYTE1 +: 8] = latch.byte1;
         end
      end
   end

   // Read data is captured in setup so that the zero-wait access returns it.
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         rdata <= 32'h0000_0000;
      end else begin
         rdata <= next_rdata;
      end
   end

   assign PRDATA = rdata;

   // ************************************************************
   // Load and erase sequencer
   // ************************************************************
   logic erase_cmd;

   assign erase_cmd = access && PWRITE && hit_ctrl && !bad && PWDATA[obcd_pkg::CTRL_ERASE];
   // Refused accesses never reach the cells.
   assign cell_wr   = access && PWRITE && (hit_b0 || hit_b1) && !bad;
   assign cell_sel  = hit_b1;

   always_comb begin
      next_state     = state;
      next_latch     = latch;
      next_loaded    = LOADED;
      next_erase_req = 1'b0;
      cell_erase     = 1'b0;
      case (state)
         obcd_pkg::ST_LOAD: begin
            // latch at reset
            // Later cell writes wait for the next reset.
            next_latch  = cells;
            next_loaded = 1'b1;
            next_state  = obcd_pkg::ST_IDLE;
         end
         obcd_pkg::ST_IDLE: begin
            // The latch decides, so a rewrite cannot dodge the wipe.
            if (erase_cmd && decoded.readout_protect) begin
               next_state     = obcd_pkg::ST_WIPE_USER;
               next_erase_req = 1'b1;
            end else if (erase_cmd) begin
               next_state = obcd_pkg::ST_WIPE_OPT;
            end
         end
         obcd_pkg::ST_WIPE_USER: begin
            // user memory first
            // Done must be held until the request falls.
            next_erase_req = !done;
            if (done) begin
               next_state = obcd_pkg::ST_WIPE_OPT;
            end
         end
         obcd_pkg::ST_WIPE_OPT: begin
            cell_erase = 1'b1;
            next_state = obcd_pkg::ST_IDLE;
         end
         default: begin
            next_state = obcd_pkg::ST_LOAD;
         end
      endcase
   end

   // The latch holds all ones during reset, which is the safest option set.
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         state          <= obcd_pkg::ST_LOAD;
         latch          <= {obcd_pkg::ERASED_BYTE, obcd_pkg::ERASED_BYTE};
         LOADED         <= 1'b0;
         USER_ERASE_REQ <= 1'b0;
      end else begin
         state          <= next_state;
         latch          <= next_latch;
         LOADED         <= next_loaded;
         USER_ERASE_REQ <= next_erase_req;
      end
   end

   // ************************************************************
   // Registered option outputs
   // ************************************************************
   logic next_rblock;
   logic next_wblock;

   always_comb begin
      next_options = decoded;
      next_rblock  = decoded.readout_protect;
      next_wblock  = decoded.readout_protect;

      next_pads    = decoded.package_sel_high ? UNBONDED_P1 : UNBONDED_P0;
   end

   // Outputs are not gated by LOADED: the one-cycle erased default is harmless.
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         OPTIONS          <= '0;
         READ_BLOCK       <= 1'b1;
         WRITE_BLOCK      <= 1'b1;
         PAD_PULLUP_FORCE <= 8'hff;
      end else begin
         OPTIONS          <= next_options;
         READ_BLOCK       <= next_rblock;
         WRITE_BLOCK      <= next_wblock;
         PAD_PULLUP_FORCE <= next_pads;
      end
   end

endmodule : obcd_option_loader

// ==== sim/obcd_chk.sv ====
// Purpose: Port assertions for the option byte loader.
// Assumes: Bound to every obcd_option_loader instance.
// Notes:   Decoded fields are judged only once the latch has settled.
`timescale 1ns/1ps
module obcd_chk #(
   parameter logic [7:0] UNBONDED_P1 = 8'h00,
   parameter logic [7:0] UNBONDED_P0 = 8'h00
) (
   input wire logic                  CLK,              // Clock.
   input wire logic                  NRST,             // Reset, low.
   input wire logic                  PSEL,             // Select.
   input wire logic                  PENABLE,          // Access phase.
   input wire logic [7:0]            PADDR,            // Address.
   input wire logic                  PREADY,           // Ready.
   input wire logic                  PSLVERR,          // Error.
   input wire logic                  PROG_MODE,        // Programming pin.
   input wire logic                  USER_ERASE_REQ,   // Wipe request.
   input wire logic                  USER_ERASE_DONE,  // Wipe done.
   input obcd_pkg::obcd_options_type OPTIONS,          // Decoded options.
   input wire logic                  READ_BLOCK,       // Read-out block.
   input wire logic                  WRITE_BLOCK,      // Write block.
   input wire logic [7:0]            PAD_PULLUP_FORCE, // Pad pull-ups.
   input wire logic                  LOADED            // Options valid.
);
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!NRST);
   // ************************************************************
   // Checks
   // ************************************************************
   // Outputs settle one edge after LOADED, hence the look back.
   a_opts_frozen: assert property ($past(LOADED, 2) |-> $stable(OPTIONS))
      else $error("options changed after load");
   a_block_follow: assert property ($past(LOADED) |-> READ_BLOCK == OPTIONS.readout_protect
      && WRITE_BLOCK == OPTIONS.readout_protect) else $error("block flags differ from protect");
   a_reset_len: assert property ($past(LOADED) |-> OPTIONS.reset_phase_cycles inside {13'h1000, 13'h0100})
      else $error("reset phase length illegal");
   a_dog_type: assert property ($past(LOADED) |-> OPTIONS.dog_always_on != OPTIONS.dog_software_select)
      else $error("watchdog type inconsistent");
   a_detect_en: assert property ($past(LOADED) |-> OPTIONS.low_supply_reset_detector ==
      (OPTIONS.voltage_detect_threshold != 2'h3) && OPTIONS.auxiliary_supply_detector ==
      OPTIONS.low_supply_reset_detector) else $error("detector enables wrong");
   a_pad_force: assert property ($past(LOADED) |-> PAD_PULLUP_FORCE ==
      (OPTIONS.package_sel_high ? UNBONDED_P1 : UNBONDED_P0)) else $error("pad pull-ups wrong");
   a_unmapped_err: assert property (PSEL && PENABLE && !(PADDR inside {8'h00, 8'h04, 8'h08, 8'h0c})
      |-> PREADY && PSLVERR) else $error("unmapped access accepted");
   a_cell_locked: assert property (PSEL && PENABLE && PADDR inside {8'h04, 8'h08} && !PROG_MODE
      && !$past(PROG_MODE) && !$past(PROG_MODE, 2) |-> PSLVERR) else $error("cell reached outside programming");
   a_wipe_cause: assert property ($rose(USER_ERASE_REQ) |-> READ_BLOCK)
      else $error("wipe requested while unprotected");
   a_wipe_hold: assert property (USER_ERASE_REQ && !USER_ERASE_DONE |=> USER_ERASE_REQ)
      else $error("wipe request dropped early");
   a_wipe_bound: assert property ($rose(USER_ERASE_DONE) |-> ##[1:6] !USER_ERASE_REQ)
      else $error("wipe request not released");
endmodule : obcd_chk

// ==== sim/obcd_prog_tool.sv ====
// Purpose: Programming tool model, the bus master of the loader.
// Assumes: Calls of xfer never overlap.
// Notes:   Released address and data lines are inverted, not held.
`timescale 1ns/1ps
module obcd_prog_tool (
   input  wire logic        clk,     // Main clock.
   output logic             psel,    // Select.
   output logic             penable, // Access phase.
   output logic             pwrite,  // Direction.
   output logic [7:0]       paddr,   // Address.
   output logic [31:0]      pwdata,  // Write data.
   output logic             prog,    // Programming mode pin.
   input  wire logic        pready,  // Ready.
   input  wire logic [31:0] prdata,  // Read data.
   input  wire logic        pslverr  // Error.
);
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      prog = 1'b0;
   end
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= (a == obcd_pkg::ADDR_BYTE0) ? (d | 32'h24) : d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      paddr <= ~a;
      pwdata <= ~pwdata;
   endtask : xfer
endmodule : obcd_prog_tool

// ==== sim/obcd_option_loader_test.sv ====
// Purpose: Self-checking bench for the option byte loader.
// Assumes: Seeded random bytes plus fixed corner pairs.
// Notes:   A mask-coded twin shares the bus and must never change.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin failures++; \
   $display("ERROR %s expected %h seen %h", nm, ex, got); end end
module obcd_option_loader_test;
   localparam logic [7:0] UNB_P1 = 8'hf0;
   localparam logic [7:0] UNB_P0 = 8'h0f;
   logic clk, nrst, npor, psel, penable, pwrite, prog, pready, pslverr, req, done, rblk, wblk, loaded;
   logic [7:0]                 paddr, pad;
   logic [31:0]                pwdata, prdata, q;
   logic                       e;
   obcd_pkg::obcd_options_type opts, m_opts;
   int                         failures = 0;
   int                         n_compared = 0;
   int                         cyc = 0;
   logic [15:0] corner [5] = '{16'hffff, 16'h2c02, 16'hf5f7, 16'h6765, 16'he631};
   obcd_prog_tool u_obcd_prog_tool (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prog(prog), .pready(pready), .prdata(prdata), .pslverr(pslverr));
   obcd_option_loader #(.UNBONDED_P1(UNB_P1), .UNBONDED_P0(UNB_P0)) u_obcd_option_loader (.CLK(clk),
      .NRST(nrst), .NPOR(npor), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
      .PWDATA(pwdata), .PREADY(pready), .PRDATA(prdata), .PSLVERR(pslverr), .PROG_MODE(prog),
      .USER_ERASE_REQ(req), .USER_ERASE_DONE(done), .OPTIONS(opts), .READ_BLOCK(rblk),
      .WRITE_BLOCK(wblk), .PAD_PULLUP_FORCE(pad), .LOADED(loaded));
   // The twin never sees a legal byte write, so its options must stay fixed.
   obcd_option_loader #(.MASK_CODED(1'b1), .MASK_BYTE0(8'h6d), .MASK_BYTE1(8'h43))
      u_obcd_option_loader_mask (.CLK(clk), .NRST(nrst), .NPOR(npor), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PREADY(), .PRDATA(), .PSLVERR(),
      .PROG_MODE(prog), .USER_ERASE_REQ(), .USER_ERASE_DONE(done), .OPTIONS(m_opts),
      .READ_BLOCK(), .WRITE_BLOCK(), .PAD_PULLUP_FORCE(), .LOADED());
   always #25 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         failures++;
         stop_test();
      end
   end
   function automatic obcd_pkg::obcd_options_type exp_opt(input logic [7:0] b0, input logic [7:0] b1,
                                                          input logic msk);
      obcd_pkg::obcd_options_type o;
      o.halt_reset_when_dog_active = b0[7];
      o.dog_software_select = b0[6];
      o.dog_always_on = ~b0[6];
      o.voltage_detect_threshold = b0[4:3];
      o.low_supply_reset_detector = (b0[4:3] != 2'h3);
      o.auxiliary_supply_detector = (b0[4:3] != 2'h3);
      o.readout_protect = b0[0] ~^ msk;
      o.package_sel_high = b1[7];
      o.reset_phase_cycles = b1[6] ? 13'h0100 : 13'h1000;
      o.clock_source_type = b1[5:4];
      o.clock_freq_range = b1[3:1];
      o.doubler_enable = ~b1[0];
      return o;
   endfunction : exp_opt
   task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
      u_obcd_prog_tool.xfer(w, a, {24'h0, d}, q, e);
   endtask : acc
   task automatic restart();
      nrst <= 1'b0;
      repeat (3) @(posedge clk);
      nrst <= 1'b1;
      repeat (4) @(posedge clk);
   endtask : restart
   task automatic chk_opts(input logic [7:0] b0, input logic [7:0] b1);
      obcd_pkg::obcd_options_type x;
      x = exp_opt(b0, b1, 1'b0);
      `CHK("options", x, opts)
      `CHK("loaded", 1'b1, loaded)
      `CHK("read_block", x.readout_protect, rblk)
      `CHK("write_block", x.readout_protect, wblk)
      `CHK("pad_force", b1[7] ? UNB_P1 : UNB_P0, pad)
      `CHK("mask_options", exp_opt(8'h6d, 8'h43, 1'b1), m_opts)
   endtask : chk_opts
   task automatic stop_test();
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : stop_test
   initial begin
      logic [7:0] b0, b1, p0, p1;
      clk = 1'b0;
      nrst = 1'b0;
      npor = 1'b0;
      done = 1'b0;
      void'($urandom(24));
      repeat (3) @(posedge clk);
      `CHK("rst_loaded", 1'b0, loaded)
      `CHK("rst_pads", 8'hff, pad)
      npor <= 1'b1;
      nrst <= 1'b1;
      repeat (4) @(posedge clk);
      chk_opts(8'he7, 8'hef);
      `CHK("delivered_clock", 2'h2, opts.clock_source_type)
      acc(1'b0, obcd_pkg::ADDR_BYTE0, 8'h00);
      `CHK("locked_err", 1'b1, e)
      `CHK("locked_data", 32'h0, q)
      acc(1'b0, 8'h10, 8'h00);
      `CHK("unmapped_err", 1'b1, e)
      u_obcd_prog_tool.prog <= 1'b1;
      repeat (3) @(posedge clk);
      p0 = 8'he7;
      p1 = 8'hef;
      for (int i = 0; i < 10; i++) begin
         b0 = (i < 5) ? corner[i][15:8] : (8'($urandom) | 8'h24);
         b1 = (i < 5) ? corner[i][7:0] : 8'($urandom);
         if (b1[5:4] == 2'h1) b1[5:4] = 2'h2;
         // doubler only at 2-4 MHz, never with RC
         if (b1[3:1] != 3'h1 || b1[5:4] == 2'h2) b1[0] = 1'b1;
         if (b1[5:4] == 2'h0) b1[6] = 1'b0;
         acc(1'b1, obcd_pkg::ADDR_BYTE0, b0);
         `CHK("wr_err", 1'b0, e)
         acc(1'b1, obcd_pkg::ADDR_BYTE1, b1);
         acc(1'b0, obcd_pkg::ADDR_BYTE1, 8'h00);
         `CHK("byte1", {24'h0, b1}, q)
         chk_opts(p0, p1);
         restart();
         chk_opts(b0, b1);
         acc(1'b0, obcd_pkg::ADDR_STATUS, 8'h00);
         `CHK("status_bytes", {b1, b0}, q[23:8])
         p0 = b0;
         p1 = b1;
      end
      acc(1'b1, obcd_pkg::ADDR_BYTE0, 8'hff);
      restart();
      acc(1'b1, obcd_pkg::ADDR_CTRL, 8'h01);
      repeat (3) @(posedge clk);
      acc(1'b0, obcd_pkg::ADDR_BYTE1, 8'h00);
      `CHK("erased_byte1", 32'hff, q)
      acc(1'b1, obcd_pkg::ADDR_BYTE0, 8'hfe);
      restart();
      acc(1'b1, obcd_pkg::ADDR_CTRL, 8'h01);
      for (int k = 0; k < 20 && req !== 1'b1; k++) @(posedge clk);
      `CHK("wipe_req", 1'b1, req)
      acc(1'b0, obcd_pkg::ADDR_BYTE0, 8'h00);
      `CHK("busy_err", 1'b1, e)
      done <= 1'b1;
      for (int k = 0; k < 20 && req !== 1'b0; k++) @(posedge clk);
      done <= 1'b0;
      repeat (3) @(posedge clk);
      acc(1'b0, obcd_pkg::ADDR_BYTE0, 8'h00);
      `CHK("wiped_byte0", 32'hff, q)
      stop_test();
   end
endmodule : obcd_option_loader_test
bind obcd_option_loader obcd_chk #(.UNBONDED_P1(UNBONDED_P1), .UNBONDED_P0(UNBONDED_P0)) u_obcd_chk (
   .CLK(CLK), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE), .PADDR(PADDR), .PREADY(PREADY),
   .PSLVERR(PSLVERR), .PROG_MODE(PROG_MODE), .USER_ERASE_REQ(USER_ERASE_REQ),
   .USER_ERASE_DONE(USER_ERASE_DONE), .OPTIONS(OPTIONS), .READ_BLOCK(READ_BLOCK),
   .WRITE_BLOCK(WRITE_BLOCK), .PAD_PULLUP_FORCE(PAD_PULLUP_FORCE), .LOADED(LOADED));
